// ==== logic/pg_hyst.sv ====
// Power-good comparator with separate on and off levels
// Assumes linear-16 levels sharing the reading's exponent
`timescale 1ns/1ps
module pg_hyst (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_en,
   input  wire logic [15:0] i_vout,
   input  wire logic [15:0] i_on_lvl,
   input  wire logic [15:0] i_off_lvl,
   output logic             o_pg
);
   import pwr_pkg::*;
   pg_st_t r, n;

   // Raise at the on level, drop at the off level or when disabled
   always_comb begin
      n = r;
      if (!i_en) n.pg = 1'b0;
      else if (i_vout >= i_on_lvl) n.pg = 1'b1;
      else if (i_vout <= i_off_lvl) n.pg = 1'b0;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) r <= '0;
      else r <= n;
   end
   assign o_pg = r.pg;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   a_pg_drop: assert property (
      (i_vout <= i_off_lvl && i_vout < i_on_lvl) |=> !o_pg)
      else $error("power good held below off level");
   a_pg_rise: assert property (
      (i_en && i_vout >= i_on_lvl) |=> o_pg)
      else $error("power good missing at on level");
endmodule : pg_hyst

// ==== logic/pwr_cmd_bank.sv ====
// Command register bank and output sequencing of a dual-channel
// power controller; commands arrive deframed, one per cycle.
// Assumes telemetry, events and run requests synchronous to the clock.
`timescale 1ns/1ps
module pwr_cmd_bank #(
   parameter int          CYC_MS   = pwr_pkg::CYC_PER_MS,
   parameter logic [23:0] MAKER_ID = 24'h414243,        // Arbitrary value
   parameter logic [55:0] MODEL_ID = 56'h50575231303030, // Arbitrary value
   parameter logic [7:0]  SERIAL   = 8'h5a              // Arbitrary value
) (
   input  wire logic           i_core_clk,
   input  wire logic           i_rst,
   input  wire pwr_pkg::cmd_t  i_cmd,
   input  wire logic [1:0]     i_run,
   input  wire pwr_pkg::telem_t i_telem,
   input  wire pwr_pkg::evt_t  i_evt,
   input  wire logic [15:0]    i_nvm_word,
   output logic [63:0]         o_rd_data,
   output logic [3:0]          o_rd_len,
   output logic                o_rd_valid,
   output logic [1:0]          o_output_enable_internal,
   output logic [1:0]          o_ramp_up,
   output logic [1:0]          o_ramp_down,
   output logic [1:0]          o_power_good,
   output logic [1:0]          o_startup_timeout_fault,
   output logic [1:0]          o_decay_warn,
   output logic [1:0][15:0]    o_comp_temp,
   output logic [15:0]         o_user_word
);
   import pwr_pkg::*;

   bank_t            r, n;
   logic             tick_w;
   logic             pg;
   logic [3:0]       sl;
   logic [1:0][3:0][7:0] clr_fl;
   logic [7:0]       clr_inp, clr_cml, set_cml;
   logic [7:0]       sb;
   logic [15:0]      sw;
   logic             rd_req, wr_req;
   logic [15:0]      ton0, tmax1;

   // Configuration slot of a paged command, none for others
   function automatic logic [3:0] slot_of(input logic [7:0] c);
      case (c)
         C_UV:    slot_of = S_UV;
         C_PGON:  slot_of = S_PGON;
         C_PGOF:  slot_of = S_PGOF;
         C_TON:   slot_of = S_TON;
         C_RISE:  slot_of = S_RISE;
         C_TMAX:  slot_of = S_TMAX;
         C_TRSP:  slot_of = S_TRSP;
         C_TOFF:  slot_of = S_TOFF;
         C_FALL:  slot_of = S_FALL;
         C_WARN:  slot_of = S_WARN;
         default: slot_of = S_NONE;
      endcase
   endfunction : slot_of

   // Millisecond tick shared by both channels
   tick_gen #(
      .CYC        (CYC_MS)
   ) u_tick (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .o_tick     (tick_w)
   );

   // Power-good comparators, one per channel
   for (genvar c = 0; c < 2; c++) begin : g_pg
      pg_hyst u_pg (
         .i_core_clk (i_core_clk),
         .i_rst      (i_rst),
         .i_en       (r.en[c]),
         .i_vout     (i_telem.ch[c].vout),
         .i_on_lvl   (r.cfg[c][S_PGON]),
         .i_off_lvl  (r.cfg[c][S_PGOF]),
         .o_pg       (o_power_good[c])
      );
   end

   // Request decode; paged commands use the current page
   assign pg = i_cmd.page;
   assign sl = slot_of(i_cmd.code);
   assign rd_req = i_cmd.valid && !i_cmd.write;
   assign wr_req = i_cmd.valid && i_cmd.write;
   assign ton0 = l11_ms(r.cfg[0][S_TON]);
   assign tmax1 = l11_ms(r.cfg[1][S_TMAX]);

   // Summaries of the selected page
   always_comb begin
      sb = 8'h00;
      sb[6] = !r.en[pg];
      sb[4] = |r.fl[pg][F_IO];
      sb[3] = |r.inp;
      sb[2] = |r.fl[pg][F_TMP];
      sb[1] = |r.cml;
      sw = {|r.fl[pg][F_VO], |r.fl[pg][F_IO], |r.inp,
            |r.fl[pg][F_MFR], !o_power_good[pg], 3'b000, sb};
   end

   // Next state: sequencer, host writes, flags and read answers
   always_comb begin
      n = r;
      n.rv = 1'b0;
      n.fault = 2'b00;
      n.warn = 2'b00;
      clr_fl = '0;
      clr_inp = 8'h00;
      clr_cml = 8'h00;
      set_cml = 8'h00;

      // Channel sequencers, timed in milliseconds
      for (int c = 0; c < 2; c++) begin
         if (tick_w && r.t[c] != 16'hffff) n.t[c] = r.t[c] + 16'd1;
         case (r.st[c])
            S_IDLE: if (i_run[c]) begin
               n.st[c] = S_OND;
               n.t[c] = 16'h0;
            end
            S_OND: if (!i_run[c]) begin
               n.st[c] = S_IDLE;
            end else if (r.t[c] >= l11_ms(r.cfg[c][S_TON])) begin
               n.st[c] = S_UP;
               n.t[c] = 16'h0;
               n.tm[c] = 16'h0;
               n.crossed[c] = 1'b0;
            end
            S_UP: if (!i_run[c]) begin
               n.st[c] = S_OFFD;
               n.t[c] = 16'h0;
            end else if (r.t[c] >= l11_ms(r.cfg[c][S_RISE])) begin
               n.st[c] = S_ON;
            end
            S_ON: if (!i_run[c]) begin
               n.st[c] = S_OFFD;
               n.t[c] = 16'h0;
            end
            S_OFFD: if (r.t[c] >= l11_ms(r.cfg[c][S_TOFF])) begin
               n.st[c] = S_DN;
               n.t[c] = 16'h0;
            end
            S_DN: if (r.t[c] >= l11_ms(r.cfg[c][S_FALL])) begin
               n.st[c] = S_DEC;
               n.t[c] = 16'h0;
            end
            S_DEC: if ({i_telem.ch[c].vout, 3'b000} <
                       {3'b000, i_telem.ch[c].vcmd}) begin
               n.st[c] = S_IDLE;
            end else if (r.t[c] >= l11_ms(r.cfg[c][S_WARN])) begin
               n.warn[c] = 1'b1;
               n.st[c] = S_IDLE;
            end
            S_SHUT: if (!i_run[c]) n.st[c] = S_IDLE;
            default: n.st[c] = S_IDLE;
         endcase

         // Start-up timeout, counted from the output enable
         if ((r.st[c] == S_UP || r.st[c] == S_ON) && !r.crossed[c]) begin
            if (i_telem.ch[c].vout > r.cfg[c][S_UV]) begin
               n.crossed[c] = 1'b1;
            end else if (r.tm[c] >= l11_ms(r.cfg[c][S_TMAX])) begin
               n.fault[c] = 1'b1;
               n.crossed[c] = 1'b1;
               if (r.cfg[c][S_TRSP][RSP_MSB:RSP_LSB] != 2'b00) begin
                  n.st[c] = S_SHUT;
               end
            end else if (tick_w) begin
               n.tm[c] = r.tm[c] + 16'd1;
            end
         end
         n.en[c] = (n.st[c] == S_UP) || (n.st[c] == S_ON);
         n.up[c] = (n.st[c] == S_UP);
         n.dn[c] = (n.st[c] == S_DN);
         n.ctemp[c] = i_telem.ch[c].temp;
      end

      // User word restored from the store once after reset
      if (!r.loaded) begin
         n.user = i_nvm_word;
         n.loaded = 1'b1;
      end

      // Host writes; flag bytes clear where written with ones
      if (wr_req) begin
         if (sl != S_NONE) begin
            n.cfg[pg][sl] = (sl == S_TRSP) ?
               {8'h00, i_cmd.wdata[7:0]} : i_cmd.wdata;
         end else begin
            case (i_cmd.code)
               C_SBYT, C_SWRD: begin
                  clr_fl[pg] = '1;
                  clr_cml = 8'hff;
               end
               C_SVO:  clr_fl[pg][F_VO] = i_cmd.wdata[7:0];
               C_SIO:  clr_fl[pg][F_IO] = i_cmd.wdata[7:0];
               C_STMP: clr_fl[pg][F_TMP] = i_cmd.wdata[7:0];
               C_SMFR: clr_fl[pg][F_MFR] = i_cmd.wdata[7:0];
               C_SINP: clr_inp = i_cmd.wdata[7:0];
               C_SCML: clr_cml = i_cmd.wdata[7:0];
               C_USER: n.user = i_cmd.wdata;
               default: set_cml[B_BADCMD] = 1'b1;
            endcase
         end
      end

      // Flag update; a new event wins over a clear
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 4; k++) begin
            n.fl[c][k] = (r.fl[c][k] & ~clr_fl[c][k]) | i_evt.ch[c][k];
         end
         n.fl[c][F_VO][B_TMAX] = n.fl[c][F_VO][B_TMAX] | n.fault[c];
         n.fl[c][F_VO][B_TOFF] = n.fl[c][F_VO][B_TOFF] | n.warn[c];
      end
      n.inp = (r.inp & ~clr_inp) | i_evt.inp;
      n.cml = (r.cml & ~clr_cml) | set_cml;

      // Read answers, registered one cycle after the request
      if (rd_req) begin
         n.rv = 1'b1;
         n.rd = 64'h0;
         n.len = 4'd2;
         if (sl != S_NONE) begin
            n.rd[15:0] = r.cfg[pg][sl];
            if (sl == S_TRSP) n.len = 4'd1;
         end else begin
            case (i_cmd.code)
               C_SBYT: begin
                  n.rd[7:0] = sb;
                  n.len = 4'd1;
               end
               C_SWRD: n.rd[15:0] = sw;
               C_SVO, C_SIO, C_STMP, C_SMFR: begin
                  n.len = 4'd1;
                  case (i_cmd.code)
                     C_SVO:   n.rd[7:0] = r.fl[pg][F_VO];
                     C_SIO:   n.rd[7:0] = r.fl[pg][F_IO];
                     C_STMP:  n.rd[7:0] = r.fl[pg][F_TMP];
                     default: n.rd[7:0] = r.fl[pg][F_MFR];
                  endcase
               end
               C_SINP: begin
                  n.rd[7:0] = r.inp;
                  n.len = 4'd1;
               end
               C_SCML: begin
                  n.rd[7:0] = r.cml;
                  n.len = 4'd1;
               end
               C_VIN:  n.rd[15:0] = i_telem.vin;
               C_IIN:  n.rd[15:0] = i_telem.iin;
               C_VOUT: n.rd[15:0] = i_telem.ch[pg].vout;
               C_IOUT: n.rd[15:0] = i_telem.ch[pg].iout;
               C_POUT: n.rd[15:0] = i_telem.ch[pg].pout;
               C_TEXT: n.rd[15:0] = i_telem.ch[pg].temp;
               C_TINT: n.rd[15:0] = i_telem.temp_int;
               C_DUTY: n.rd[15:0] = i_telem.ch[pg].duty;
               C_REV: begin
                  n.rd[7:0] = REV_VAL;
                  n.len = 4'd1;
               end
               C_MID: begin
                  n.rd[23:0] = MAKER_ID;
                  n.len = 4'd3;
               end
               C_MOD: begin
                  n.rd[55:0] = MODEL_ID;
                  n.len = 4'd7;
               end
               C_SER: begin
                  n.rd[7:0] = SERIAL;
                  n.len = 4'd1;
               end
               C_VMAX: n.rd[15:0] = pg ? VMAX1 : VMAX0;
               C_USER: n.rd[15:0] = r.user;
               default: begin
                  n.len = 4'd0;
                  n.cml[B_BADCMD] = 1'b1;
               end
            endcase
         end
      end
   end

   // State register with documented defaults
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         r <= '0;
         r.cfg <= {2{CFG_RST}};
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign o_rd_data = r.rd;
   assign o_rd_len = r.len;
   assign o_rd_valid = r.rv;
   assign o_output_enable_internal = r.en;
   assign o_ramp_up = r.up;
   assign o_ramp_down = r.dn;
   assign o_startup_timeout_fault = r.fault;
   assign o_decay_warn = r.warn;
   assign o_comp_temp = r.ctemp;
   assign o_user_word = r.user;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_enter_rise;
      r.st[0] == S_OND ##1 r.st[0] == S_UP;
   endsequence

   a_on_delay_held: assert property (s_enter_rise |->
      $past(r.t[0]) >= $past(ton0)) else $error("rise began early");
   a_timeout_late: assert property (r.fault[1] |->
      $past(r.tm[1]) >= $past(tmax1)) else $error("timeout too early");
   a_decay_warn: assert property (r.warn[0] |->
      $past(r.st[0]) == S_DEC && r.st[0] == S_IDLE)
      else $error("warning outside decay");
   a_fall_off: assert property (r.st[0] == S_DN |->
      o_ramp_down[0] && !o_output_enable_internal[0])
      else $error("enable held during fall");
   a_rev_value: assert property ((rd_req && i_cmd.code == C_REV) |=>
      o_rd_valid && o_rd_data == 64'h11 && o_rd_len == 4'd1)
      else $error("bad revision answer");
   a_ro_write: assert property ((wr_req && i_cmd.code == C_VIN) |=>
      r.cml[B_BADCMD]) else $error("read-only write not flagged");
   a_input_shared: assert property (
      (rd_req && i_cmd.code == C_SINP) |=> o_rd_data[7:0] == $past(r.inp))
      else $error("input flags paged");
endmodule : pwr_cmd_bank

// ==== logic/tick_gen.sv ====
// Millisecond tick generator for the sequencing timers
// Assumes CYC of at least two core cycles
`timescale 1ns/1ps
module tick_gen #(
   parameter int CYC = pwr_pkg::CYC_PER_MS
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   output logic      o_tick
);
   import pwr_pkg::*;
   tick_st_t r, n;

   // Count down one period, then pulse
   always_comb begin
      n = r;
      n.tick = (r.cnt == 32'd0);
      n.cnt = n.tick ? 32'(CYC - 1) : r.cnt - 32'd1;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) r <= '0;
      else r <= n;
   end
   assign o_tick = r.tick;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   a_tick_one_cycle: assert property (o_tick |=> !o_tick)
      else $error("tick lasted more than one cycle");
endmodule : tick_gen

// ==== shared/pwr_pkg.sv ====
// Constants and carrier types of the power command register bank
// Assumes one 100 MHz core clock and two output channels
package pwr_pkg;
   // Clock rate and the millisecond base of all sequencing timers
   localparam int CLK_MHZ    = 100;
   localparam int MS_IN_US   = 1000;
   localparam int CYC_PER_MS = CLK_MHZ * MS_IN_US;

   // Command codes
   localparam logic [7:0] C_UV   = 8'h44, C_PGON = 8'h5e, C_PGOF = 8'h5f;
   localparam logic [7:0] C_TON  = 8'h60, C_RISE = 8'h61, C_TMAX = 8'h62;
   localparam logic [7:0] C_TRSP = 8'h63, C_TOFF = 8'h64, C_FALL = 8'h65;
   localparam logic [7:0] C_WARN = 8'h66, C_SBYT = 8'h78, C_SWRD = 8'h79;
   localparam logic [7:0] C_SVO  = 8'h7a, C_SIO  = 8'h7b, C_SINP = 8'h7c;
   localparam logic [7:0] C_STMP = 8'h7d, C_SCML = 8'h7e, C_SMFR = 8'h80;
   localparam logic [7:0] C_VIN  = 8'h88, C_IIN  = 8'h89, C_VOUT = 8'h8b;
   localparam logic [7:0] C_IOUT = 8'h8c, C_TEXT = 8'h8d, C_TINT = 8'h8e;
   localparam logic [7:0] C_DUTY = 8'h94, C_POUT = 8'h96, C_REV  = 8'h98;
   localparam logic [7:0] C_MID  = 8'h99, C_MOD  = 8'h9a, C_SER  = 8'h9e;
   localparam logic [7:0] C_VMAX = 8'ha5, C_USER = 8'hb0;

   // Slots of the per-channel configuration words
   localparam logic [3:0] S_UV = 4'h0, S_PGON = 4'h1, S_PGOF = 4'h2;
   localparam logic [3:0] S_TON = 4'h3, S_RISE = 4'h4, S_TMAX = 4'h5;
   localparam logic [3:0] S_TRSP = 4'h6, S_TOFF = 4'h7, S_FALL = 4'h8;
   localparam logic [3:0] S_WARN = 4'h9, S_NONE = 4'hf;
   localparam int N_SLOT = 10;
   localparam logic [N_SLOT-1:0][15:0] CFG_RST = {
      16'hf258, 16'hd200, 16'h8000, 16'h00b8, 16'hd280,
      16'hd200, 16'h8000, 16'h0eb8, 16'h0ee1, 16'h0e66};

   // Flag bytes, bit positions and fixed values
   localparam int F_VO = 0, F_IO = 1, F_TMP = 2, F_MFR = 3;
   localparam int B_TMAX = 2, B_TOFF = 1, B_BADCMD = 7;
   localparam int RSP_MSB = 7, RSP_LSB = 6;
   localparam logic [7:0]  REV_VAL = 8'h11;
   localparam logic [15:0] VMAX0 = 16'h4189; // 4.096 V, exponent -12
   localparam logic [15:0] VMAX1 = 16'h5800; // 5.5 V, exponent -12

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_OND = 3'b001, S_UP = 3'b010, S_ON = 3'b011,
      S_OFFD = 3'b100, S_DN = 3'b101, S_DEC = 3'b110, S_SHUT = 3'b111
   } seq_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        page;
      logic [7:0]  code;
      logic [15:0] wdata;
   } cmd_t;

   typedef struct packed {
      logic [15:0] vout, iout, temp, duty, pout, vcmd;
   } ch_telem_t;

   typedef struct packed {
      logic [15:0]          vin, iin, temp_int;
      ch_telem_t [1:0]      ch;
   } telem_t;

   typedef struct packed {
      logic [1:0][3:0][7:0] ch;
      logic [7:0]           inp;
   } evt_t;

   typedef struct packed {
      logic [1:0][N_SLOT-1:0][15:0] cfg;
      logic [1:0][3:0][7:0] fl;
      logic [7:0]           inp, cml;
      logic [15:0]          user;
      logic                 loaded;
      logic [63:0]          rd;
      logic [3:0]           len;
      logic                 rv;
      seq_t [1:0]           st;
      logic [1:0][15:0]     t, tm, ctemp;
      logic [1:0]           crossed, fault, warn, en, up, dn;
   } bank_t;

   typedef struct packed { logic pg; } pg_st_t;
   typedef struct packed { logic [31:0] cnt; logic tick; } tick_st_t;

   // Linear-11 milliseconds to a whole count, negatives as zero
   function automatic logic [15:0] l11_ms(input logic [15:0] w);
      logic [4:0]  e;
      logic [41:0] v;
      e = w[15:11];
      v = {32'h0, w[9:0]};
      if (w[10]) v = 42'h0;
      else if (e[4]) v = v >> (5'd0 - e);
      else v = v << e;
      l11_ms = (|v[41:16]) ? 16'hffff : v[15:0];
   endfunction : l11_ms
endpackage : pwr_pkg

// ==== testbench/host_model.sv ====
// Host side model issuing deframed register commands
// Assumes the bank answers a read one cycle after taking it
`timescale 1ns/1ps
module host_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_rd_valid,
   input  wire logic [63:0] i_rd_data,
   input  wire logic [3:0]  i_rd_len,
   output pwr_pkg::cmd_t    o_cmd
);
   import pwr_pkg::*;
   initial o_cmd = '0;

   // One command per call, held for one taking edge
   task automatic xfer(input logic wr, input logic pg, input logic [7:0] cd,
      input logic [15:0] wd, output logic [63:0] rd, output logic [3:0] ln,
      output logic ok);
      @(negedge i_core_clk);
      o_cmd = '{1'b1, wr, pg, cd, wd}; // Page rides with code
      @(negedge i_core_clk);
      o_cmd.valid = 1'b0;
      ok = (i_rd_valid === !wr);
      rd = i_rd_data;
      ln = i_rd_len;
   endtask : xfer
endmodule : host_model

// ==== testbench/pwr_cmd_bank_test.sv ====
// Self-checking bench of the power command register bank
// Assumes a 100 MHz clock and a four-cycle millisecond
`timescale 1ns/1ps
module pwr_cmd_bank_test;
   import pwr_pkg::*;
   localparam int          MS  = 4;
   localparam logic [23:0] MKR = 24'h313233;         // Arbitrary value
   localparam logic [55:0] MDL = 56'h41424344454647; // Arbitrary value
   localparam logic [7:0]  SRL = 8'h77;              // Arbitrary value
   logic             clk, rst, rv, ok;
   cmd_t             cmd;
   logic [1:0]       run, en, up, dn, pg, tf, dw;
   telem_t           tel;
   evt_t             evt;
   logic [15:0]      nvm, uw;
   logic [63:0]      rd, d;
   logic [3:0]       rl, l;
   logic [1:0][15:0] ct;
   int               mismatches, num_checks, c;

   pwr_cmd_bank #(.CYC_MS(MS), .MAKER_ID(MKR), .MODEL_ID(MDL),
      .SERIAL(SRL)) u_pwr_cmd_bank (.i_core_clk(clk), .i_rst(rst),
      .i_cmd(cmd), .i_run(run), .i_telem(tel), .i_evt(evt),
      .i_nvm_word(nvm), .o_rd_data(rd), .o_rd_len(rl), .o_rd_valid(rv),
      .o_output_enable_internal(en), .o_ramp_up(up), .o_ramp_down(dn),
      .o_power_good(pg), .o_startup_timeout_fault(tf),
      .o_decay_warn(dw), .o_comp_temp(ct), .o_user_word(uw));
   host_model u_host_model (.i_core_clk(clk), .i_rd_valid(rv),
      .i_rd_data(rd), .i_rd_len(rl), .o_cmd(cmd));

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Value compare, counts and reports
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Cycle count compare against a window
   task automatic cnt(input int v, input int lo, input int hi);
      chk({63'h0, v >= lo && v <= hi}, 64'h1);
   endtask : cnt

   // Read compare: data, length and answer strobe
   task automatic rdc(input logic p, input logic [7:0] cd,
      input logic [63:0] e, input logic [3:0] n);
      u_host_model.xfer(1'b0, p, cd, 16'h0, d, l, ok);
      chk(d, e);
      chk({60'h0, l}, {60'h0, n});
      chk({63'h0, ok}, 64'h1);
   endtask : rdc

   // Write, then no answer strobe may follow
   task automatic wr(input logic p, input logic [7:0] cd,
      input logic [15:0] w);
      u_host_model.xfer(1'b1, p, cd, w, d, l, ok);
      chk({63'h0, ok}, 64'h1);
   endtask : wr

   // Bounded wait until one bit of a pair reaches a level
   task automatic wt(ref logic [1:0] s, input int i, input logic v,
      input int n);
      c = 0;
      while (s[i] !== v && c < n) begin
         @(negedge clk);
         c++;
      end
   endtask : wt

   // Reset values, fixed and identity words
   task automatic t_defaults;
      logic [15:0] ex [10] = '{16'h0e66, 16'h0ee1, 16'h0eb8,
         16'h8000, 16'hd200, 16'hd280, 16'h00b8,
         16'h8000, 16'hd200, 16'hf258};
      logic [7:0] cd [10] = '{C_UV, C_PGON, C_PGOF, C_TON, C_RISE, C_TMAX,
         C_TRSP, C_TOFF, C_FALL, C_WARN};
      for (int k = 0; k < 10; k++)
         rdc(1'b1, cd[k], {48'h0, ex[k]}, (k == 6) ? 4'h1 : 4'h2);
      rdc(1'b1, C_REV, 64'h11, 4'h1);
      rdc(1'b0, C_VMAX, 64'h4189, 4'h2);
      rdc(1'b1, C_VMAX, 64'h5800, 4'h2);
      rdc(1'b1, C_MID, {40'h0, MKR}, 4'h3);
      rdc(1'b0, C_MOD, {8'h0, MDL}, 4'h7);
      rdc(1'b1, C_SER, {56'h0, SRL}, 4'h1);
      rdc(1'b1, C_USER, 64'hc0de, 4'h2);
   endtask : t_defaults

   // Paged words, byte store, shared user word
   task automatic t_paged;
      wr(1'b1, C_PGOF, 16'h0e00);
      rdc(1'b1, C_PGOF, 64'h0e00, 4'h2);
      rdc(1'b0, C_PGOF, 64'h0eb8, 4'h2);
      wr(1'b0, C_TRSP, 16'h12c0);
      rdc(1'b0, C_TRSP, 64'hc0, 4'h1);
      wr(1'b0, C_TRSP, 16'h00b8);
      wr(1'b0, C_USER, 16'h5aa5);
      rdc(1'b1, C_USER, 64'h5aa5, 4'h2);
      chk({48'h0, uw}, 64'h5aa5);
   endtask : t_paged

   // Writes to read-only codes and a read of an unknown code
   task automatic t_refuse;
      wr(1'b0, C_VOUT, 16'h1234);
      wr(1'b0, C_REV, 16'h0022);
      wr(1'b0, C_VIN, 16'h0001);
      rdc(1'b0, C_REV, 64'h11, 4'h1);
      rdc(1'b1, C_SCML, 64'h80, 4'h1);
      wr(1'b0, C_SCML, 16'h0080);
      rdc(1'b0, C_SCML, 64'h0, 4'h1);
      rdc(1'b0, 8'hc3, 64'h0, 4'h0);
      wr(1'b0, C_SCML, 16'h0080);
   endtask : t_refuse

   // Telemetry words and the compensation temperature
   task automatic t_telem;
      @(negedge clk);
      tel.vin = 16'hd310;
      tel.temp_int = 16'he0a0;
      tel.ch[1].vout = 16'h1111;
      tel.ch[1].duty = 16'hc320;
      tel.ch[1].temp = 16'he190;
      tel.ch[0].temp = 16'he088;
      rdc(1'b1, C_VIN, 64'hd310, 4'h2);
      rdc(1'b1, C_VOUT, 64'h1111, 4'h2);
      rdc(1'b1, C_DUTY, 64'hc320, 4'h2);
      rdc(1'b1, C_TINT, 64'he0a0, 4'h2);
      rdc(1'b1, C_TEXT, 64'he190, 4'h2);
      chk({32'h0, ct}, 64'he190e088);
   endtask : t_telem

   // Sticky flags, shared input byte and summaries
   task automatic t_flags;
      @(negedge clk);
      evt.inp = 8'h10;
      evt.ch[1][1] = 8'h20;
      @(negedge clk);
      evt = '0;
      rdc(1'b0, C_SINP, 64'h10, 4'h1);
      rdc(1'b1, C_SIO, 64'h20, 4'h1);
      rdc(1'b0, C_SIO, 64'h0, 4'h1);
      rdc(1'b1, C_SBYT, 64'h58, 4'h1);
      rdc(1'b1, C_SWRD, 64'h6858, 4'h2);
      wr(1'b1, C_SWRD, 16'h0000);
      rdc(1'b1, C_SIO, 64'h0, 4'h1);
      rdc(1'b1, C_SINP, 64'h10, 4'h1);
      wr(1'b0, C_SINP, 16'h0010);
   endtask : t_flags

   // Channel zero on, power good levels, off with decay warning
   task automatic t_seq;
      tel.ch[0].vout = 16'h0ec0;
      tel.ch[0].vcmd = 16'h0ec0;
      wr(1'b0, C_WARN, 16'h0002);
      run[0] = 1'b1;
      wt(en, 0, 1'b1, 8);
      cnt(c, 1, 3);
      wt(up, 0, 1'b0, 60);
      cnt(c, 27, 36);
      rdc(1'b0, C_SVO, 64'h0, 4'h1);
      chk({63'h0, pg[0]}, 64'h0);
      tel.ch[0].vout = 16'h0ee1;
      wt(pg, 0, 1'b1, 6);
      cnt(c, 0, 5);
      tel.ch[0].vout = 16'h0ec0;
      repeat (4) @(negedge clk);
      chk({63'h0, pg[0]}, 64'h1);
      tel.ch[0].vout = 16'h0eb8;
      wt(pg, 0, 1'b0, 6);
      cnt(c, 1, 5);
      run[0] = 1'b0;
      wt(dn, 0, 1'b1, 8);
      cnt(c, 1, 3);
      wt(dn, 0, 1'b0, 60);
      cnt(c, 27, 36);
      wt(dw, 0, 1'b1, 30);
      cnt(c, 3, 13);
      rdc(1'b0, C_SVO, 64'h02, 4'h1);
      wr(1'b0, C_SVO, 16'h0002);
   endtask : t_seq

   // Channel one never crosses undervolt level: shut, then continue
   task automatic t_timeout;
      tel.ch[1].vout = 16'h0e66;
      run[1] = 1'b1;
      wt(en, 1, 1'b1, 8);
      cnt(c, 1, 3);
      wt(tf, 1, 1'b1, 60);
      cnt(c, 35, 45);
      wt(en, 1, 1'b0, 4);
      cnt(c, 0, 3);
      rdc(1'b1, C_SVO, 64'h04, 4'h1);
      run[1] = 1'b0;
      wr(1'b1, C_TRSP, 16'h0000);
      run[1] = 1'b1;
      wt(en, 1, 1'b1, 8);
      cnt(c, 1, 3);
      wt(tf, 1, 1'b1, 60);
      cnt(c, 35, 45);
      chk({63'h0, en[1]}, 64'h1);
      run[1] = 1'b0;
   endtask : t_timeout

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   // Reset then scenarios
   initial begin
      rst = 1'b1;
      run = '0;
      tel = '0;
      evt = '0;
      nvm = 16'hc0de;
      mismatches = 0;
      num_checks = 0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_defaults();
      t_paged();
      t_refuse();
      t_telem();
      t_flags();
      t_seq();
      t_timeout();
      print_verdict();
   end
endmodule : pwr_cmd_bank_test
